// File: hdl/rpm_divider.sv
// Purpose: One-cycle enable pulse generator standing in for an oscillator.
// Assumes: Enable low means the oscillator is stopped and the count holds at zero.
// Notes: First pulse comes DIV cycles after enable rises.
module rpm_divider import rpm_pkg::*; #(
  parameter int unsigned DIV = 5
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic enable,
  output logic tick
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_tick;

  always_comb begin
    next_count = CNT_ZERO;
    next_tick = 1'b0;
    if (enable) begin
      if (count == CNT_W'(DIV - 1)) begin
        next_tick = 1'b1;
      end else begin
        next_count = count + CNT_ONE;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count <= CNT_ZERO;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end

endmodule // rpm_divider

// File: hdl/rpm_pkg.sv
// Purpose: Shared types and constants for the reset and power mode controller.
// Assumes: One 200 MHz system clock; oscillator domains are modelled as enables.
// Notes: Timing figures are kept in their own unit and converted to cycles here.
package rpm_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned FAST_OSC_MHZ = 40;
  localparam int unsigned SLOW_OSC_KHZ = 32;
  // Fast oscillator enable divider: 200 MHz / 40 MHz.
  localparam int unsigned FAST_DIV = CLK_MHZ / FAST_OSC_MHZ;
  // Slow oscillator enable divider, rounded down.
  localparam int unsigned SLOW_DIV = (CLK_MHZ * 1000) / SLOW_OSC_KHZ;
  // Power-up stabilization delay in microseconds (plain default).
  localparam int unsigned PWRUP_US = 64;
  localparam int unsigned PWRUP_CYCLES = PWRUP_US * CLK_MHZ;
  localparam int unsigned CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [2:0] RX_ALL = 3'h5;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RPM_PROCESSING,
    RPM_APPROACH,
    RPM_DEEP_SLEEP
  } rpm_mode_e;

  // Reset sources, all active high inside the block.
  typedef struct packed {
    logic clear_pin;
    logic software;
    logic power_on;
    logic brownout;
    logic watchdog;
  } rpm_rst_src_s;

  // Host configuration messages, each a one-cycle pulse.
  typedef struct packed {
    logic go_processing;
    logic go_approach;
    logic go_deep_sleep;
    logic i2c_start;
  } rpm_host_msg_s;

  // Per-mode power configuration.
  typedef struct packed {
    logic [CNT_W-1:0] wake_period;
    logic [2:0] approach_rx;
  } rpm_cfg_s;

endpackage

// File: hdl/rpm_top.sv
// Purpose: Reset combining, oscillator gating and operation mode sequencing.
// Assumes: All inputs synchronous to clock; host messages are one-cycle pulses.
// Notes: Oscillators appear as enable pulses; outputs are registered.
// Operation
// - Merge all reset sources into one reset.
// - Five sources: clear, software, power-on, brownout, watchdog.
// - Extend power-up while brownout still active.
// - Fast oscillator clocks transmit, converter, processor.
// - Fast oscillator stopped throughout Deep Sleep.
// - Slow oscillator clocks power-saving modes.
// - Three modes, configured by host messages.
// - Enter Processing on message, approach, resets.
// - Leave Processing on message, time-out, watchdog.
// - Approach mode entry, exit and rx channels.
// - Wake-up timer periodically runs approach scans.
// - Deep Sleep halts processor, watchdog; host-only entry.
// - Deep Sleep resumes on I2C start, clear.
// - Programmable slow-clocked wake-up timer period.
module rpm_top import rpm_pkg::*; #(
  parameter int unsigned PWRUP_COUNT = PWRUP_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic external_clear_pin_n,
  input wire logic software_reset_request,
  input wire logic power_on_reset,
  input wire logic brownout_reset,
  input wire logic watchdog_reset,
  input wire rpm_host_msg_s host_msg,
  input wire rpm_cfg_s cfg,
  input wire logic approach_detected,
  input wire logic inactivity_timeout,
  input wire logic hand_absent_timeout,
  output logic system_reset_out,
  output rpm_mode_e mode,
  output logic fast_osc_run,
  output logic fast_tick,
  output logic slow_tick,
  output logic signal_processor_run,
  output logic watchdog_enable,
  output logic approach_scan,
  output logic [2:0] rx_active
);

  // ---------------------------------------------------------------------------
  // Reset combining
  // ---------------------------------------------------------------------------
  rpm_rst_src_s src;
  logic any_src;
  logic [31:0] pwr_count;
  logic [31:0] next_pwr_count;
  logic next_system_reset;

  assign src = '{clear_pin: ~external_clear_pin_n, software: software_reset_request,
                 power_on: power_on_reset, brownout: brownout_reset, watchdog: watchdog_reset};
  assign any_src = |src;

  // The count only runs once every source is quiet, so a brownout that outlasts
  // the power-up delay keeps the reset asserted until it lifts.
  always_comb begin
    next_pwr_count = pwr_count;
    next_system_reset = system_reset_out;
    if (any_src) begin
      next_pwr_count = 32'h0;
      next_system_reset = 1'b1;
    end else if (pwr_count < PWRUP_COUNT) begin
      next_pwr_count = pwr_count + 32'h1;
    end else begin
      next_system_reset = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pwr_count <= 32'h0;
      system_reset_out <= 1'b1;
    end else begin
      pwr_count <= next_pwr_count;
      system_reset_out <= next_system_reset;
    end
  end

  // ---------------------------------------------------------------------------
  // Oscillators
  // ---------------------------------------------------------------------------
  logic fast_en;
  logic fast_pulse;
  logic slow_pulse;

  assign fast_en = (mode != RPM_DEEP_SLEEP);

  rpm_divider #(.DIV(FAST_DIV)) u_fast_osc (
    .clock(clock),
    .resetn(resetn),
    .enable(fast_en),
    .tick(fast_pulse)
  );

  // The slow oscillator never stops; it keeps the wake-up timer alive.
  rpm_divider #(.DIV(SLOW_DIV)) u_slow_osc (
    .clock(clock),
    .resetn(resetn),
    .enable(1'b1),
    .tick(slow_pulse)
  );

  // ---------------------------------------------------------------------------
  // Mode controller
  // ---------------------------------------------------------------------------
  rpm_mode_e next_mode;
  logic [CNT_W-1:0] wake_count;
  logic [CNT_W-1:0] next_wake_count;
  logic next_scan;

  always_comb begin
    next_mode = mode;
    if (system_reset_out) begin
      next_mode = RPM_PROCESSING;
    end else begin
      case (mode)
        RPM_PROCESSING: begin
          // Watchdog exit goes through the reset path and lands back here.
          if (host_msg.go_deep_sleep) begin
            next_mode = RPM_DEEP_SLEEP;
          end else if (host_msg.go_approach || inactivity_timeout) begin
            next_mode = RPM_APPROACH;
          end
        end
        RPM_APPROACH: begin
          if (host_msg.go_deep_sleep) begin
            next_mode = RPM_DEEP_SLEEP;
          end else if (approach_detected || host_msg.i2c_start || host_msg.go_processing) begin
            next_mode = RPM_PROCESSING;
          end
        end
        RPM_DEEP_SLEEP: begin
          if (host_msg.i2c_start || host_msg.go_processing) begin
            next_mode = RPM_PROCESSING;
          end else if (host_msg.go_approach) begin
            next_mode = RPM_APPROACH;
          end
        end
        default: begin
          next_mode = RPM_PROCESSING;
        end
      endcase
      if (mode == RPM_PROCESSING && hand_absent_timeout && !host_msg.go_deep_sleep) begin
        next_mode = RPM_APPROACH;
      end
    end
  end

  // Wake-up timer counts slow ticks only in approach mode.
  always_comb begin
    next_wake_count = wake_count;
    next_scan = 1'b0;
    if (mode != RPM_APPROACH || system_reset_out) begin
      next_wake_count = CNT_ZERO;
    end else if (slow_pulse) begin
      if (wake_count + CNT_ONE >= cfg.wake_period) begin
        next_wake_count = CNT_ZERO;
        next_scan = 1'b1;
      end else begin
        next_wake_count = wake_count + CNT_ONE;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode <= RPM_PROCESSING;
      wake_count <= CNT_ZERO;
      approach_scan <= 1'b0;
    end else begin
      mode <= next_mode;
      wake_count <= next_wake_count;
      approach_scan <= next_scan;
    end
  end

  // ---------------------------------------------------------------------------
  // Registered mode outputs
  // ---------------------------------------------------------------------------
  logic next_fast_osc_run;
  logic next_fast_tick;
  logic next_slow_tick;
  logic next_signal_processor_run;
  logic next_watchdog_enable;
  logic [2:0] next_rx_active;

  // Outputs lag the mode by one edge so that every top-level pin leaves a flop.
  always_comb begin
    next_fast_osc_run = fast_en;
    next_fast_tick = fast_pulse;
    next_slow_tick = slow_pulse;
    next_signal_processor_run = !system_reset_out && mode != RPM_DEEP_SLEEP;
    next_watchdog_enable = !system_reset_out && mode != RPM_DEEP_SLEEP;
    next_rx_active = RX_ALL;
    if (mode == RPM_APPROACH) begin
      next_rx_active = cfg.approach_rx;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fast_osc_run <= 1'b1;
      fast_tick <= 1'b0;
      slow_tick <= 1'b0;
      signal_processor_run <= 1'b0;
      watchdog_enable <= 1'b0;
      rx_active <= RX_ALL;
    end else begin
      fast_osc_run <= next_fast_osc_run;
      fast_tick <= next_fast_tick;
      slow_tick <= next_slow_tick;
      signal_processor_run <= next_signal_processor_run;
      watchdog_enable <= next_watchdog_enable;
      rx_active <= next_rx_active;
    end
  end

endmodule // rpm_top

// File: testbench/rpm_checker.sv
// Purpose: Concurrent checks at the ports of the mode controller.
// Assumes: One clock; resetn only initialises the flops.
// Notes: Reset hold is checked over eight cycles, the bench measures the rest.
module rpm_checker import rpm_pkg::*; #(
  parameter int unsigned PWRUP_COUNT = 20
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic external_clear_pin_n,
  input wire logic software_reset_request,
  input wire logic power_on_reset,
  input wire logic brownout_reset,
  input wire logic watchdog_reset,
  input wire rpm_host_msg_s host_msg,
  input wire logic approach_detected,
  input wire logic hand_absent_timeout,
  input wire logic system_reset_out,
  input wire rpm_mode_e mode,
  input wire logic fast_osc_run,
  input wire logic fast_tick,
  input wire logic signal_processor_run,
  input wire logic watchdog_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  logic src;
  logic go;
  assign src = !external_clear_pin_n | software_reset_request | power_on_reset | brownout_reset | watchdog_reset;
  assign go = !system_reset_out && !src;
  a_src_holds_reset:
    assert property (src |=> system_reset_out [*8]) else $error("reset not held after a source");
  a_start_proc:
    assert property ($fell(system_reset_out) |-> mode == RPM_PROCESSING) else $error("reset left outside Processing");
  a_deep_entry:
    assert property (go && host_msg.go_deep_sleep |=> mode == RPM_DEEP_SLEEP) else $error("deep sleep not entered");
  a_deep_cause:
    assert property (mode != RPM_DEEP_SLEEP ##1 mode == RPM_DEEP_SLEEP |-> $past(host_msg.go_deep_sleep))
    else $error("deep sleep without message");
  a_deep_osc_off:
    assert property (mode == RPM_DEEP_SLEEP |=> !fast_osc_run && !signal_processor_run && !watchdog_enable)
    else $error("clock or processor running in deep sleep");
  a_tick_gated:
    assert property (!fast_osc_run ##1 !fast_osc_run |-> !fast_tick) else $error("fast tick while stopped");
  a_deep_wake:
    assert property (mode == RPM_DEEP_SLEEP && go && host_msg == 4'h1 |=> mode == RPM_PROCESSING)
    else $error("no wake on start condition");
  a_approach_in:
    assert property (mode == RPM_PROCESSING && go && hand_absent_timeout && host_msg == 4'h0 |=> mode == RPM_APPROACH)
    else $error("approach mode not entered");
  a_approach_out:
    assert property (mode == RPM_APPROACH && go && approach_detected && host_msg == 4'h0 |=> mode == RPM_PROCESSING)
    else $error("no wake on hand detection");
endmodule // rpm_checker
bind rpm_top rpm_checker #(.PWRUP_COUNT(PWRUP_COUNT)) rpm_checker_i (.clock(clock), .resetn(resetn),
  .external_clear_pin_n(external_clear_pin_n), .software_reset_request(software_reset_request),
  .power_on_reset(power_on_reset), .brownout_reset(brownout_reset), .watchdog_reset(watchdog_reset),
  .host_msg(host_msg), .approach_detected(approach_detected), .hand_absent_timeout(hand_absent_timeout),
  .system_reset_out(system_reset_out), .mode(mode), .fast_osc_run(fast_osc_run), .fast_tick(fast_tick),
  .signal_processor_run(signal_processor_run), .watchdog_enable(watchdog_enable));

// File: testbench/rpm_host_model.sv
// Purpose: Host side that sends configuration messages to the controller.
// Assumes: Called just after a clock edge.
// Notes: Each message is a one-cycle pulse; the bus goes quiet between them.
module rpm_host_model import rpm_pkg::*; (
  input wire logic clock,
  output rpm_host_msg_s host_msg
);
  initial host_msg = '0;
  // Bit k of the message struct, counted from i2c_start upward.
  task automatic send(input int unsigned k);
    host_msg = rpm_host_msg_s'(4'h1 << k);
    @(posedge clock);
    #1;
    host_msg = '0;
    // One quiet edge keeps back-to-back messages apart on the bus.
    @(posedge clock);
    #1;
  endtask
endmodule // rpm_host_model

// File: testbench/testbench.sv
// Purpose: Directed scenarios for reset merging and mode sequencing.
// Assumes: Power-up count shortened to 20 cycles.
// Notes: Scan spacing needs two slow periods, so the run is long.
module testbench import rpm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PW = 20;
  logic clock, resetn, clr_n, sw, por, bor, wd, appr, inact, hand;
  logic sro, fosc, ftick, stick, signal_processor, wde, scan;
  logic [2:0] rx;
  rpm_host_msg_s host_msg;
  rpm_cfg_s cfg;
  rpm_mode_e mode;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  rpm_host_model rpm_host_model_i (.clock(clock), .host_msg(host_msg));
  rpm_top #(.PWRUP_COUNT(PW)) rpm_top_i (.clock(clock), .resetn(resetn), .external_clear_pin_n(clr_n),
    .software_reset_request(sw), .power_on_reset(por), .brownout_reset(bor), .watchdog_reset(wd),
    .host_msg(host_msg), .cfg(cfg), .approach_detected(appr), .inactivity_timeout(inact),
    .hand_absent_timeout(hand), .system_reset_out(sro), .mode(mode), .fast_osc_run(fosc), .fast_tick(ftick),
    .slow_tick(stick), .signal_processor_run(signal_processor), .watchdog_enable(wde), .approach_scan(scan), .rx_active(rx));
  // ------------
  // Helpers
  // ------------
  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_rel(output int n);
    n = 0;
    while (sro !== 1'b0 && n < 100) begin
      step(1);
      n++;
    end
  endtask
  task automatic wait_scan(output int n);
    n = 1;
    step(1);
    while (scan !== 1'b1 && n < 20000) begin
      step(1);
      n++;
    end
  endtask
  task automatic close_out();
    $display("Errors %0d, checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ------------
  // Scenarios
  // ------------
  task automatic t_sources();
    int n;
    for (int k = 0; k < 5; k++) begin
      {clr_n, sw, por, bor, wd} = 5'h10 ^ (5'h10 >> k);
      step(30);
      cmp(sro, 1'b1);
      {clr_n, sw, por, bor, wd} = 5'h10;
      wait_rel(n);
      cmp(n >= PW && n <= PW + 5, 1'b1);
      cmp(mode, RPM_PROCESSING);
    end
  endtask
  task automatic t_deep();
    int n;
    rpm_host_model_i.send(1);
    cmp(mode, RPM_DEEP_SLEEP);
    for (int i = 0; i < 10; i++) begin
      step(1);
      cmp({fosc, signal_processor, wde, ftick}, 4'h0);
    end
    rpm_host_model_i.send(0);
    cmp(mode, RPM_PROCESSING);
    n = 0;
    // The restarted oscillator gives its first tick one period after the wake edge.
    for (int i = 0; i < 15; i++) begin
      cmp({fosc, signal_processor, wde}, 3'h7);
      n += ftick;
      step(1);
    end
    cmp(n, 2);
    rpm_host_model_i.send(1);
    clr_n = 0;
    step(2);
    cmp(sro, 1'b1);
    clr_n = 1;
    wait_rel(n);
    cmp(mode, RPM_PROCESSING);
  endtask
  task automatic t_approach();
    int n;
    hand = 1;
    step(1);
    hand = 0;
    cmp(mode, RPM_APPROACH);
    step(1);
    cmp(rx, 3'h2);
    wait_scan(n);
    wait_scan(n);
    cmp(n, 2 * SLOW_DIV);
    cmp(stick, 1'b1);
    appr = 1;
    step(1);
    appr = 0;
    cmp(mode, RPM_PROCESSING);
    step(1);
    cmp(rx, RX_ALL);
    inact = 1;
    step(1);
    inact = 0;
    cmp(mode, RPM_APPROACH);
    rpm_host_model_i.send(3);
    cmp(mode, RPM_PROCESSING);
    rpm_host_model_i.send(2);
    cmp(mode, RPM_APPROACH);
    rpm_host_model_i.send(0);
    cmp(mode, RPM_PROCESSING);
    rpm_host_model_i.send(0);
    cmp(mode, RPM_PROCESSING);
    rpm_host_model_i.send(1);
    cmp(mode, RPM_DEEP_SLEEP);
    rpm_host_model_i.send(3);
    cmp(mode, RPM_PROCESSING);
    rpm_host_model_i.send(2);
    cmp(mode, RPM_APPROACH);
    rpm_host_model_i.send(1);
    cmp(mode, RPM_DEEP_SLEEP);
    rpm_host_model_i.send(2);
    cmp(mode, RPM_APPROACH);
    wd = 1;
    step(1);
    wd = 0;
    cmp(sro, 1'b1);
    wait_rel(n);
    cmp(mode, RPM_PROCESSING);
  endtask
  initial begin
    int n;
    {clr_n, sw, por, bor, wd} = 5'h10;
    {appr, inact, hand} = 3'h0;
    cfg = {16'h0002, 3'h2};
    resetn = 0;
    step(10);
    resetn = 1;
    cmp(sro, 1'b1);
    wait_rel(n);
    cmp(n >= PW && n <= PW + 5, 1'b1);
    t_sources();
    t_deep();
    t_approach();
    close_out();
  end
endmodule // testbench
